// File: hdl/regbuf_consts.svh
`ifndef REGBUF_CONSTS_SVH
`define REGBUF_CONSTS_SVH

// Command/address word: address 16, bank 3, ras, cas, we.
`define CA_BITS      22
`define ADDR_BITS    16
`define BANK_BITS    3
`define CKE_BITS     2
`define ODT_BITS     2
`define RANK_BITS    4
`define FIFO_DEPTH   8
`define FIFO_AW      3
// Register-access opcode: all four rank selects asserted (active low).
`define RANK_ALL_ON  4'h0
`define RANK_NONE    4'hf
`define RANK_PAIR_NONE 2'h3

`endif

// File: hdl/regbuf_pkg.sv
package regbuf_pkg;
`include "regbuf_consts.svh"

   typedef struct packed {
      logic [`ADDR_BITS-1:0] addr;
      logic [`BANK_BITS-1:0] bank;
      logic                  rasN;
      logic                  casN;
      logic                  weN;
   } cmd_s;

   typedef struct packed {
      cmd_s                  cmd;
      logic [`CKE_BITS-1:0]  cke;
      logic [`ODT_BITS-1:0]  odt;
      logic [`RANK_BITS-1:0] rankN;
   } word_s;

   localparam int WORD_W = $bits(word_s);

endpackage : regbuf_pkg

// File: hdl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Filling side.
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side.
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_reg;
   logic [AW-1:0]    rdPtr_reg;
   logic [AW:0]      count_reg;
   wire              doWrite = inValid && inReady;
   wire              doRead  = outValid && outReady;

   assign inReady  = (count_reg != (AW+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData  = mem[rdPtr_reg];

   always_ff @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (doWrite) wrPtr_reg <= wrPtr_reg + 1'b1;
         if (doRead)  rdPtr_reg <= rdPtr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
      end
   end
endmodule : word_fifo

// File: hdl/registered_cmd_addr_parity.sv
`timescale 1ns/1ps
// What this block does
// - Capture inputs on rising clock crossing.
// - Drive command, address, enables and termination on two copies.
// - Two-rank mode: duplicate two rank selects.
// - Quad mode: four rank selects, one each.
// - Re-drive word or access internal control.
// - Even parity compared with next-cycle parity_in.
// - Mismatch pulls parity_error_n low.
// - Exclude enables, termination, rank selects.
// - Check only when a rank select asserted.
// - Back mount keeps input termination enabled.
// - Quad select pin pulled up internally.
`include "regbuf_consts.svh"

module registered_cmd_addr_parity
   import regbuf_pkg::*;
(
   // Clock and reset.
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   // Straps.
   input  wire logic                  quadSelectEnablePin,
   input  wire logic                  quadSelectPinDriven,
   input  wire logic                  backMountSelect,
   // Host command and address inputs.
   input  wire cmd_s                  cmdIn,
   input  wire logic [`CKE_BITS-1:0]  clockEnableIn,
   input  wire logic [`ODT_BITS-1:0]  terminationCtrlIn,
   input  wire logic [`RANK_BITS-1:0] rankSelectInN,
   input  wire logic                  parityIn,
   // Downstream stall from the output drivers.
   input  wire logic                  outReady,
   output logic                       inReady,
   // Output copies, side A and side B.
   output cmd_s                       cmdOutA,
   output cmd_s                       cmdOutB,
   output logic [`CKE_BITS-1:0]       ckeOutA,
   output logic [`CKE_BITS-1:0]       ckeOutB,
   output logic [`ODT_BITS-1:0]       odtOutA,
   output logic [`ODT_BITS-1:0]       odtOutB,
   output logic [1:0]                 rankSelectOutAN,
   output logic [1:0]                 rankSelectOutBN,
   output logic [`RANK_BITS-1:0]      rankSelectOutN,
   output logic                       outValid,
   // Internal control access strobe.
   output logic                       ctrlAccess,
   output cmd_s                       ctrlWord,
   // Termination and parity error (open drain).
   output logic                       inputTermination,
   output logic                       parityErrorOut,
   output logic                       parityErrorOe
);
   // Two-flop synchronisers for the straps; they come from pins.
   logic [2:0] strapMeta_reg;
   logic [2:0] strap_reg;
   logic       quadMode_reg;
   logic       quadMode_next;

   word_s      cap_reg;
   logic       capValid_reg;
   logic       capCheck_reg;
   logic       capParity_reg;

   word_s      fifoOut;
   logic       fifoValid;
   logic       fifoReady;
   logic       fifoInReady;

   // Pull-up: an undriven strap reads high and so selects two-rank mode.
   wire quadPinLevel = strap_reg[1] ? strap_reg[0] : 1'b1;
   assign quadMode_next = ~quadPinLevel;

   // A strap change reaches the mode three clocks after the pin moves; the
   // straps are meant to be static, so words in flight are not realigned.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         strapMeta_reg <= '0;
         strap_reg     <= '0;
         quadMode_reg  <= 1'b0;
      end else begin
         strapMeta_reg <= {backMountSelect, quadSelectPinDriven,
                           quadSelectEnablePin};
         strap_reg     <= strapMeta_reg;
         quadMode_reg  <= quadMode_next;
      end
   end

   // Rank selects in two-rank mode use only the low two inputs.
   wire [`RANK_BITS-1:0] rankMasked = quadMode_reg ? rankSelectInN :
                                      {`RANK_PAIR_NONE, rankSelectInN[1:0]};
   wire                  anyRank    = (rankMasked != `RANK_NONE);
   wire                  isCtrl     = (rankMasked == `RANK_ALL_ON);
   // Parity over command and address only.
   wire                  calcParity = ^cmdIn;

   // Every clock's word but a control access enters the FIFO while it has room; idle clocks carry no rank select
   // and pass through as such, which keeps the output latency fixed.
   // Captured at the rising edge of the true clock.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cap_reg       <= '0;
         capValid_reg  <= 1'b0;
         capCheck_reg  <= 1'b0;
         capParity_reg <= 1'b0;
      end else begin
         cap_reg       <= '{cmdIn, clockEnableIn, terminationCtrlIn,
                            rankMasked};
         capValid_reg  <= fifoInReady && !isCtrl;
         capCheck_reg  <= anyRank;
         capParity_reg <= calcParity;
      end
   end

   // Parity arrives one clock after its word.
   wire mismatch = capCheck_reg && (capParity_reg != parityIn);

   // The error is a one-clock pulse per failing word rather than a latched
   // flag, so whoever listens must watch the pin on every clock.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         parityErrorOe  <= 1'b0;
         parityErrorOut <= 1'b0;
      end else begin
         parityErrorOe  <= mismatch;
         parityErrorOut <= 1'b0;
      end
   end

   // ctrlWord follows the bus every clock; ctrlAccess marks a real access.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlAccess       <= 1'b0;
         ctrlWord         <= '0;
         inputTermination <= 1'b1;
      end else begin
         ctrlAccess       <= isCtrl;
         ctrlWord         <= cmdIn;
         inputTermination <= strap_reg[2] | (|terminationCtrlIn);
      end
   end

   // Eight words absorb a downstream stall; beyond that, words are dropped.
   word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) outFifo (
      .clk      (clk),
      .reset_n  (reset_n),
      .inValid  (capValid_reg),
      .inReady  (fifoInReady),
      .inData   (cap_reg),
      .outValid (fifoValid),
      .outReady (fifoReady),
      .outData  (fifoOut)
   );

   // A word leaves the FIFO whenever the output register is empty or taken.
   assign fifoReady = outReady || !outValid;

   // The ready seen outside lags the FIFO by one clock; the capture gating
   // uses the FIFO's own flag, so no word is lost to that lag.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         inReady <= 1'b0;
      end else begin
         inReady <= fifoInReady;
      end
   end

   // Rank-select fan-out: pairs in two-rank mode, singles in quad mode.
   wire [1:0]            rankPairN = fifoOut.rankN[1:0];
   wire [`RANK_BITS-1:0] rankQuadN = quadMode_reg ? fifoOut.rankN :
                                     `RANK_NONE;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         outValid <= 1'b0;
      end else if (fifoReady) begin
         outValid <= fifoValid;
      end
   end

   // Side A copy.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmdOutA         <= '0;
         ckeOutA         <= '0;
         odtOutA         <= '0;
         rankSelectOutAN <= `RANK_PAIR_NONE;
      end else if (fifoReady) begin
         cmdOutA         <= fifoOut.cmd;
         ckeOutA         <= fifoOut.cke;
         odtOutA         <= fifoOut.odt;
         rankSelectOutAN <= rankPairN;
      end
   end

   // Side B copy; it mirrors side A bit for bit.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmdOutB         <= '0;
         ckeOutB         <= '0;
         odtOutB         <= '0;
         rankSelectOutBN <= `RANK_PAIR_NONE;
      end else if (fifoReady) begin
         cmdOutB         <= fifoOut.cmd;
         ckeOutB         <= fifoOut.cke;
         odtOutB         <= fifoOut.odt;
         rankSelectOutBN <= rankPairN;
      end
   end

   // Quad-mode singles; they stay deasserted in two-rank mode.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rankSelectOutN <= `RANK_NONE;
      end else if (fifoReady) begin
         rankSelectOutN <= rankQuadN;
      end
   end
endmodule : registered_cmd_addr_parity

// File: tb/regbuf_properties.sv
`timescale 1ns/1ps
module regbuf_checker
   import regbuf_pkg::*;
(
   // Clock, reset and straps.
   input logic       clk,
   input logic       reset_n,
   input logic       quadSelectEnablePin,
   input logic       quadSelectPinDriven,
   input logic       backMountSelect,
   // Host side.
   input cmd_s       cmdIn,
   input logic [3:0] rankSelectInN,
   input logic       parityIn,
   input logic       outReady,
   // Outputs.
   input cmd_s       cmdOutA,
   input cmd_s       cmdOutB,
   input logic [1:0] ckeOutA,
   input logic [1:0] ckeOutB,
   input logic [1:0] odtOutA,
   input logic [1:0] odtOutB,
   input logic [1:0] rankSelectOutAN,
   input logic [1:0] rankSelectOutBN,
   input logic [3:0] rankSelectOutN,
   input logic       outValid,
   input logic       ctrlAccess,
   input logic       inputTermination,
   input logic       parityErrorOut,
   input logic       parityErrorOe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence badPar;
      rankSelectInN[1:0] != 2'h3 ##1 parityIn != ^$past(cmdIn);
   endsequence
   sequence goodPar;
      1'h1 ##1 parityIn == ^$past(cmdIn);
   endsequence
   sequence noSel;
      rankSelectInN == 4'hf ##1 1'h1;
   endsequence
   // The straps reach the rank outputs four clocks after the pins.
   sequence twoRankOut;
      outValid && $past(quadSelectEnablePin || !quadSelectPinDriven, 4);
   endsequence
   // Control access is decoded only once quad mode has settled.
   sequence ctrlReq;
      rankSelectInN == 4'h0 &&
      $past(!quadSelectEnablePin && quadSelectPinDriven, 3);
   endsequence
   a_err_on_bad: assert property (badPar |=> parityErrorOe)
      else $error("parity mismatch not flagged");
   a_quiet_match: assert property (goodPar |=> !parityErrorOe)
      else $error("error flagged on good parity");
   a_quiet_nosel: assert property (noSel |=> !parityErrorOe)
      else $error("error flagged without rank select");
   a_open_drain: assert property (parityErrorOut == 1'h0)
      else $error("error pin driven high");
   a_two_rank: assert property (twoRankOut |->
      rankSelectOutAN == rankSelectOutBN && rankSelectOutN == 4'hf)
      else $error("two-rank outputs wrong");
   a_copies_equal: assert property (outValid |-> cmdOutA == cmdOutB &&
      ckeOutA == ckeOutB && odtOutA == odtOutB)
      else $error("output copies differ");
   a_term_back: assert property (backMountSelect [*3] |=>
      inputTermination)
      else $error("termination off in back mount");
   a_ctrl_pulse: assert property (ctrlReq |=> ctrlAccess)
      else $error("control access missing");
   a_stall_hold: assert property (outValid && !outReady |=> outValid &&
      $stable(cmdOutA))
      else $error("output changed during stall");
endmodule : regbuf_checker

bind registered_cmd_addr_parity regbuf_checker u_chk (.*);

// File: tb/cmd_host_model.sv
`timescale 1ns/1ps
module cmd_host_model
   import regbuf_pkg::*;
(
   // Bench control.
   input  logic       clk,
   input  logic       go,
   input  logic       badPar,
   input  cmd_s       wordIn,
   input  logic [3:0] rankIn,
   // Host pins.
   output cmd_s       cmdIn,
   output logic [3:0] rankSelectInN,
   output logic       parityIn
);
   logic badD = 1'h0;
   initial begin
      cmdIn = '0;
      rankSelectInN = 4'hf;
      parityIn = 1'h0;
   end
   // Idle cycles invert the bus so a stale word is never mistaken for data.
   always @(posedge clk) begin
      cmdIn <= go ? wordIn : ~cmdIn;
      rankSelectInN <= go ? rankIn : 4'hf;
      badD <= badPar;
      parityIn <= ^cmdIn ^ badD;
   end
endmodule : cmd_host_model

// File: tb/registered_cmd_addr_parity_tb_top.sv
`timescale 1ns/1ps
module registered_cmd_addr_parity_tb_top
   import regbuf_pkg::*;
;
   logic clk = 0, reset_n = 0, quadPin = 1, pinDriven = 1, backMount = 0;
   logic outReady = 1, go = 0, badPar = 0, quad = 0;
   logic [1:0] cke = 0, odt = 0, rankOutAN;
   logic [3:0] rank = 4'hf, rankN, rankOutN;
   logic parityIn, inReady, outValid, ctrlAccess, term, errOe;
   cmd_s word = '0, cmdIn, cmdOutA, ctrlWord;
   int nMismatch = 0, nTests = 0, errCnt = 0, ctlSeen = 0;
   word_s q[$];
   wire sel = quad ? rankOutN != 4'hf : rankOutAN != 2'h3;
   always #12.5 clk = ~clk;
   cmd_host_model u_host (.clk(clk), .go(go), .badPar(badPar),
      .wordIn(word), .rankIn(rank), .cmdIn(cmdIn),
      .rankSelectInN(rankN), .parityIn(parityIn));
   registered_cmd_addr_parity u_dut (.clk(clk), .reset_n(reset_n),
      .quadSelectEnablePin(quadPin), .quadSelectPinDriven(pinDriven),
      .backMountSelect(backMount), .cmdIn(cmdIn), .clockEnableIn(cke),
      .terminationCtrlIn(odt), .rankSelectInN(rankN), .parityIn(parityIn),
      .outReady(outReady), .inReady(inReady), .cmdOutA(cmdOutA),
      .cmdOutB(), .ckeOutA(), .ckeOutB(), .odtOutA(), .odtOutB(),
      .rankSelectOutAN(rankOutAN), .rankSelectOutBN(),
      .rankSelectOutN(rankOutN), .outValid(outValid),
      .ctrlAccess(ctrlAccess), .ctrlWord(ctrlWord),
      .inputTermination(term), .parityErrorOut(), .parityErrorOe(errOe));
   task automatic chk(input logic [31:0] got, exp);
      nTests++;
      if (got !== exp) begin
         nMismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   always @(posedge clk) begin
      if (errOe === 1'h1) errCnt++;
      if (ctrlAccess === 1'h1) begin
         ctlSeen++;
         chk(ctrlWord, word);
      end
      if (outValid && outReady && sel) begin
         if (q.size() == 0) chk(1, 0);
         else begin
            chk(cmdOutA, q[0].cmd);
            chk(quad ? rankOutN : {2'h0, rankOutAN},
               quad ? q[0].rankN : {2'h0, q[0].rankN[1:0]});
            void'(q.pop_front());
         end
      end
   end
   task automatic send(input cmd_s w, input logic [3:0] r, input logic b, p);
      if (p) q.push_back('{w, 2'h0, 2'h0, r});
      word <= w;
      rank <= r;
      badPar <= b;
      go <= 1'h1;
      cke <= ~cke;
      odt <= ~odt;
      @(posedge clk);
   endtask : send
   task automatic idle(input int n);
      go <= 1'h0;
      badPar <= 1'h0;
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic drain();
      for (int i = 0; i < 40 && q.size() > 0; i++) @(posedge clk);
      chk(q.size(), 0);
   endtask : drain
   task automatic t_two();
      send(22'h2aaaa5, 4'he, 0, 1);
      send(22'h15555a, 4'hd, 0, 1);
      send(22'h3fffff, 4'hc, 0, 1);
      idle(1);
      drain();
      chk(errCnt, 0);
   endtask : t_two
   task automatic t_par();
      errCnt = 0;
      send(22'h000001, 4'he, 1, 1);
      send(22'h000003, 4'hf, 1, 0);
      idle(6);
      chk(errCnt, 1);
      drain();
   endtask : t_par
   task automatic t_quad();
      quadPin <= 1'h0;
      quad <= 1'h1;
      idle(4);
      send(22'h0000aa, 4'h7, 0, 1);
      send(22'h000055, 4'h3, 0, 1);
      idle(1);
      drain();
      // An undriven strap must read as two-rank mode.
      pinDriven <= 1'h0;
      quad <= 1'h0;
      idle(4);
      send(22'h001234, 4'hd, 0, 1);
      idle(1);
      drain();
      quadPin <= 1'h1;
      pinDriven <= 1'h1;
   endtask : t_quad
   task automatic t_ctrl();
      odt <= 2'h0;
      quadPin <= 1'h0;
      quad <= 1'h1;
      idle(4);
      chk(term, 0);
      backMount <= 1'h1;
      send(22'h00beef, 4'h0, 0, 0);
      odt <= 2'h0;
      idle(5);
      chk(ctlSeen, 1);
      chk(term, 1);
      backMount <= 1'h0;
      quadPin <= 1'h1;
      quad <= 1'h0;
      idle(4);
   endtask : t_ctrl
   task automatic t_fill();
      outReady <= 1'h0;
      for (int i = 0; i < 30 && inReady !== 1'h0; i++) @(posedge clk);
      chk(inReady, 0);
      send(22'h0000f0, 4'he, 0, 0);
      idle(3);
      outReady <= 1'h1;
      idle(20);
      drain();
   endtask : t_fill
   task automatic final_report();
      if (nMismatch == 0 && nTests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      idle(4);
      t_two();
      t_par();
      t_quad();
      t_ctrl();
      t_fill();
      final_report();
   end
   initial begin
      #100000;
      nMismatch++;
      final_report();
   end
endmodule : registered_cmd_addr_parity_tb_top
